// File: verilog/wtc_pkg.sv
// shared constants and types for the watchdog timer control block
package wtc_pkg;
	// register indices as printed; byte address on the bus is four times the index
	localparam logic [7:0] WTC_CTRL_IDX = 8'h34;
	localparam logic [7:0] WTC_CODE_IDX = 8'h35;
	localparam logic [7:0] WTC_STAT_IDX = 8'h36;
	localparam logic [9:0] WTC_CTRL_ADDR = {WTC_CTRL_IDX, 2'b00};
	localparam logic [9:0] WTC_CODE_ADDR = {WTC_CODE_IDX, 2'b00};
	localparam logic [9:0] WTC_STAT_ADDR = {WTC_STAT_IDX, 2'b00};

	// control register fields
	localparam int WTC_OVF_SEL_BIT = 0;
	localparam int WTC_DTS_LSB = 1;
	localparam int WTC_EN_BIT = 3;
	localparam int WTC_TRAP_ACT_BIT = 4;
	localparam int WTC_TRAP_AREA_BIT = 5;
	localparam logic [5:0] WTC_CTRL_RESET = 6'h39;

	// status register fields
	localparam int WTC_ST_RUN_BIT = 0;
	localparam int WTC_ST_CNT_LSB = 1;
	localparam int WTC_ST_SEL_BIT = 3;
	localparam int WTC_ST_TRAP_BIT = 4;

	// control codes
	localparam logic [7:0] WTC_CODE_CLEAR = 8'h4e;
	localparam logic [7:0] WTC_CODE_DISABLE = 8'hb1;
	localparam logic [7:0] WTC_CODE_TRAP = 8'hd2;

	// divider taps: the two-stage counter adds two more bits to each detection time
	localparam int WTC_FC_LONGEST_EXP = 25;
	localparam int WTC_FS_LONGEST_EXP = 17;
	localparam int WTC_BIN_STAGES = 2;
	localparam int WTC_DIV_W = 24;

	// reset hold: at most 24 high-frequency periods; sys_clk serves as that clock
	localparam int WTC_CLK_PERIOD_PS = 10_000;
	localparam int WTC_FC_PERIOD_PS = 10_000;
	localparam int WTC_RST_MAX_FC_PERIODS = 24;
	localparam int WTC_RST_CYCLES = (WTC_RST_MAX_FC_PERIODS * WTC_FC_PERIOD_PS) / WTC_CLK_PERIOD_PS;
	localparam logic [4:0] WTC_RST_CNT_INIT = 5'(WTC_RST_CYCLES - 1);

	typedef struct packed {
		logic cpu_hold_mode;
		logic low_speed_run_mode;
		logic divider_source_select;
		logic low_freq_tick;
	} wtc_mode_s;
endpackage : wtc_pkg

// File: verilog/wtc_divider.sv
// free-running prefix divider with a selectable tap
`timescale 1ns/1ps
`default_nettype none
module wtc_divider
	import wtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic count_en,
	input wire logic [4:0] tap_shift,
	output logic tick
);
	typedef struct packed {
		logic [WTC_DIV_W-1:0] cnt;
	} wtc_div_s;

	wtc_div_s st_q, st_d;
	logic [WTC_DIV_W-1:0] mask;

	always_comb begin
		st_d = st_q;
		mask = (WTC_DIV_W'(1) << tap_shift) - WTC_DIV_W'(1);
		// only the count pauses; the tap position never resets the divider
		if (count_en) begin
			st_d.cnt = st_q.cnt + WTC_DIV_W'(1);
		end
		tick = count_en && ((st_q.cnt & mask) == mask);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : wtc_divider
`default_nettype wire

// File: verilog/wtc_reset_stretch.sv
// holds the internal reset request for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
module wtc_reset_stretch
	import wtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic trigger,
	output logic active
);
	typedef struct packed {
		logic act;
		logic [4:0] cnt;
	} wtc_rst_s;

	wtc_rst_s st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (st_q.act) begin
			if (st_q.cnt == 5'h0) begin
				st_d.act = 1'b0;
			end else begin
				st_d.cnt = st_q.cnt - 5'h1;
			end
		end else if (trigger) begin
			st_d.act = 1'b1;
			st_d.cnt = WTC_RST_CNT_INIT;
		end
	end

	assign active = st_q.act;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : wtc_reset_stretch
`default_nettype wire

// File: verilog/wtc_watchdog.sv
// watchdog timer with avalon-mm register access
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module wtc_watchdog
	import wtc_pkg::*;
#(
	// exponents of the longest detection times; lower them to shorten simulation
	parameter int FC_LONGEST_EXP = WTC_FC_LONGEST_EXP,
	parameter int FS_LONGEST_EXP = WTC_FS_LONGEST_EXP
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire wtc_mode_s mode,
	output logic watchdog_nmi_request,
	output logic wd_reset_request,
	output logic trap_area_commit
);
	typedef struct packed {
		logic ack;
		logic waitreq;
		logic [31:0] rdata;
		logic wd_run_enable;
		logic run;
		logic [1:0] detect_time_select;
		logic overflow_action_select;
		logic trap_action_select;
		logic trap_area_select;
		logic trap_commit;
		logic [1:0] bin_cnt;
		logic nmi;
	} wtc_state_s;

	wtc_state_s st_q, st_d;

	logic slow_src;
	logic [4:0] fc_shift;
	logic [4:0] fs_shift;
	logic fc_tick;
	logic fs_tick;
	logic div_tick;
	logic overflow;
	logic rst_active;
	logic wr_take;
	logic rd_take;
	logic [7:0] wbyte;

	// outside cpu hold mode, fast source counts every cycle; slow source counts on each low-frequency strobe
	assign slow_src = mode.divider_source_select | mode.low_speed_run_mode;
	assign fc_shift = 5'(FC_LONGEST_EXP - WTC_BIN_STAGES - 2 * int'(st_q.detect_time_select));
	assign fs_shift = 5'(FS_LONGEST_EXP - WTC_BIN_STAGES - 2 * int'(st_q.detect_time_select));

	wtc_divider u_fc_div (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.count_en(!mode.cpu_hold_mode),
		.tap_shift(fc_shift),
		.tick(fc_tick)
	);

	wtc_divider u_fs_div (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.count_en(!mode.cpu_hold_mode && mode.low_freq_tick),
		.tap_shift(fs_shift),
		.tick(fs_tick)
	);

	assign div_tick = slow_src ? fs_tick : fc_tick;
	assign overflow = st_q.run && div_tick && (st_q.bin_cnt == 2'b11);

	wtc_reset_stretch u_rst (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.trigger(overflow && st_q.overflow_action_select),
		.active(rst_active)
	);

	// a write is served at the edge where waitrequest is seen low; a read is sampled one edge earlier, while it is high
	assign wr_take = write && st_q.ack;
	assign rd_take = read && !st_q.ack;
	assign wbyte = writedata[7:0];

	always_comb begin
		st_d = st_q;
		st_d.nmi = 1'b0;
		st_d.ack = (read || write) && !st_q.ack;
		// own flop so the bus pin has no gate after the register
		st_d.waitreq = !st_d.ack;

		if (rd_take) begin
			st_d.rdata = '0;
			// control and code registers read as zero; only status shows state
			if (address == WTC_STAT_ADDR) begin
				st_d.rdata[WTC_ST_RUN_BIT] = st_q.run;
				st_d.rdata[WTC_ST_CNT_LSB +: 2] = st_q.bin_cnt;
				st_d.rdata[WTC_ST_SEL_BIT] = st_q.overflow_action_select;
				st_d.rdata[WTC_ST_TRAP_BIT] = st_q.trap_commit;
			end else if (address == WTC_CTRL_ADDR) begin
				st_d.rdata = '0;
			end
		end

		// counting and overflow
		if (st_q.run) begin
			if (div_tick) begin
				st_d.bin_cnt = st_q.bin_cnt + 2'b01;
			end
		end else begin
			st_d.bin_cnt = 2'b00;
		end
		if (overflow && !st_q.overflow_action_select) begin
			// no master-flag input: the request cannot be masked here
			st_d.nmi = 1'b1;
		end

		// register writes
		if (wr_take && byteenable[0]) begin
			if (address == WTC_CTRL_ADDR) begin
				st_d.wd_run_enable = wbyte[WTC_EN_BIT];
				st_d.detect_time_select = wbyte[WTC_DTS_LSB +: 2];
				st_d.overflow_action_select = st_q.overflow_action_select & wbyte[WTC_OVF_SEL_BIT];
				st_d.trap_action_select = wbyte[WTC_TRAP_ACT_BIT];
				st_d.trap_area_select = wbyte[WTC_TRAP_AREA_BIT];
				if (wbyte[WTC_EN_BIT]) begin
					st_d.run = 1'b1;
				end
			end else if (address == WTC_CODE_ADDR) begin
				case (wbyte)
					WTC_CODE_CLEAR: begin
						st_d.bin_cnt = 2'b00;
					end
					WTC_CODE_DISABLE: begin
						if (!st_q.wd_run_enable) begin
							st_d.run = 1'b0;
							st_d.bin_cnt = 2'b00;
						end
					end
					WTC_CODE_TRAP: begin
						st_d.trap_commit = st_q.trap_area_select;
					end
					default: begin
					end
				endcase
			end
		end

		// watchdog reset reinitialises the control fields, counter and requests, but not the dividers or bus flops, as part of the internal hardware
		if (rst_active) begin
			st_d.wd_run_enable = WTC_CTRL_RESET[WTC_EN_BIT];
			st_d.run = 1'b1;
			st_d.detect_time_select = WTC_CTRL_RESET[WTC_DTS_LSB +: 2];
			st_d.overflow_action_select = WTC_CTRL_RESET[WTC_OVF_SEL_BIT];
			st_d.trap_action_select = WTC_CTRL_RESET[WTC_TRAP_ACT_BIT];
			st_d.trap_area_select = WTC_CTRL_RESET[WTC_TRAP_AREA_BIT];
			st_d.trap_commit = 1'b0;
			st_d.bin_cnt = 2'b00;
			st_d.nmi = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.ack <= 1'b0;
			st_q.waitreq <= 1'b1;
			st_q.rdata <= '0;
			st_q.wd_run_enable <= WTC_CTRL_RESET[WTC_EN_BIT];
			st_q.run <= 1'b1;
			st_q.detect_time_select <= WTC_CTRL_RESET[WTC_DTS_LSB +: 2];
			st_q.overflow_action_select <= WTC_CTRL_RESET[WTC_OVF_SEL_BIT];
			st_q.trap_action_select <= WTC_CTRL_RESET[WTC_TRAP_ACT_BIT];
			st_q.trap_area_select <= WTC_CTRL_RESET[WTC_TRAP_AREA_BIT];
			st_q.trap_commit <= 1'b0;
			st_q.bin_cnt <= 2'b00;
			st_q.nmi <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign readdata = st_q.rdata;
	assign waitrequest = st_q.waitreq;
	assign watchdog_nmi_request = st_q.nmi;
	assign wd_reset_request = rst_active;
	assign trap_area_commit = st_q.trap_commit;
endmodule : wtc_watchdog
`default_nettype wire

// File: tb/wtc_props.sv
// concurrent checks on the watchdog timer control ports
`timescale 1ns/1ps
`default_nettype none
module wtc_props
	import wtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire wtc_mode_s mode,
	input wire logic watchdog_nmi_request,
	input wire logic wd_reset_request,
	input wire logic trap_area_commit
);
	logic [5:0] hi_q;
	logic sel_zero_q;
	logic stat_rd;
	assign stat_rd = read && !waitrequest && address == WTC_STAT_ADDR;
	// remembers that software has chosen the interrupt action since reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			sel_zero_q <= 1'b0;
		else if (write && !waitrequest && address == WTC_CTRL_ADDR && byteenable[0] && !writedata[WTC_OVF_SEL_BIT])
			sel_zero_q <= 1'b1;
	end
	// counts how long the internal reset has been held so far
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			hi_q <= 6'h00;
		else if (wd_reset_request)
			hi_q <= hi_q + 6'h01;
		else
			hi_q <= 6'h00;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_nmi_pulse: assert property (watchdog_nmi_request |=> !watchdog_nmi_request)
		else $error("nmi request longer than one cycle");
	a_rst_hold: assert property ($fell(wd_reset_request) |-> hi_q == 6'h18)
		else $error("reset hold not 24 cycles");
	a_rst_max: assert property (wd_reset_request |-> hi_q < 6'h18)
		else $error("reset hold too long");
	a_rst_no_nmi: assert property (wd_reset_request |-> !watchdog_nmi_request)
		else $error("nmi during reset action");
	a_hold_quiet: assert property (mode.cpu_hold_mode [*3] |-> !watchdog_nmi_request)
		else $error("overflow while held");
	a_ctrl_read: assert property (read && !waitrequest && address == WTC_CTRL_ADDR |-> readdata == 32'h0000_0000)
		else $error("control read not zero");
	a_trap_cause: assert property ($rose(trap_area_commit) |->
		$past(write && !waitrequest && address == WTC_CODE_ADDR && writedata[7:0] == WTC_CODE_TRAP))
		else $error("trap commit without code");
	a_sel_sticky: assert property (sel_zero_q && stat_rd |-> !readdata[WTC_ST_SEL_BIT])
		else $error("action select returned to reset");
	a_off_cleared: assert property (stat_rd && !readdata[WTC_ST_RUN_BIT] |-> readdata[WTC_ST_CNT_LSB +: 2] == 2'b00)
		else $error("counter not cleared while off");
	a_wait_answer: assert property ($rose(read || write) |=> !waitrequest)
		else $error("no answer after one wait");
	a_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
endmodule : wtc_props
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the watchdog timer control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import wtc_pkg::*;
	logic sys_clk = 0, nrst = 0, read = 0, write = 0, waitrequest, nmi, rst_req, trap;
	logic [9:0] address = 10'h000;
	logic [31:0] writedata = 32'h0000_0000, readdata, rd;
	logic [3:0] byteenable = 4'hf;
	logic [7:0] c;
	wtc_mode_s mode = '0;
	int n_mismatch = 0, n_checks = 0, seed = 32'ha9ce, t, i, p;
	// reference model of the control state as software sees it
	int m_en = 1, m_run = 1, m_sel = 1, m_area = 1, m_trap = 0;
	always #5 sys_clk = ~sys_clk;
	// short exponents keep the longest detection time near a thousand cycles
	wtc_watchdog #(.FC_LONGEST_EXP(10), .FS_LONGEST_EXP(8)) wtc_watchdog_i (.sys_clk(sys_clk), .nrst(nrst),
		.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .mode(mode), .watchdog_nmi_request(nmi),
		.wd_reset_request(rst_req), .trap_area_commit(trap));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] stat_m();
		return (32'(m_run) << WTC_ST_RUN_BIT) | (32'(m_sel) << WTC_ST_SEL_BIT) | (32'(m_trap) << WTC_ST_TRAP_BIT);
	endfunction : stat_m
	task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
		address <= a;
		writedata <= {24'h00_0000, d};
		read <= !wr;
		write <= wr;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		rd = readdata;
		if (wr && byteenable[0] && a == WTC_CTRL_ADDR) begin
			m_en = d[WTC_EN_BIT];
			m_sel = m_sel & d[WTC_OVF_SEL_BIT];
			m_area = d[WTC_TRAP_AREA_BIT];
			m_run = m_run | d[WTC_EN_BIT];
		end
		if (wr && byteenable[0] && a == WTC_CODE_ADDR) begin
			if (d == WTC_CODE_DISABLE && m_en == 0)
				m_run = 0;
			if (d == WTC_CODE_TRAP)
				m_trap = m_area;
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask : acc
	task automatic wait_for(input int lim);
		t = 0;
		while (nmi !== 1'b1 && rst_req !== 1'b1 && t < lim) begin
			@(posedge sys_clk);
			t++;
		end
	endtask : wait_for
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		acc(0, WTC_STAT_ADDR, 8'h00);
		chk("status after reset", rd & 32'h19, stat_m());
		acc(0, WTC_CTRL_ADDR, 8'h00);
		chk("control read", rd, 32'h0);
		acc(0, 10'h3fc, 8'h00);
		chk("unmapped read", rd, 32'h0);
		acc(1, WTC_CTRL_ADDR, 8'h3f);
		acc(1, WTC_CODE_ADDR, WTC_CODE_CLEAR);
		wait_for(100);
		chk("reset action", rst_req, 1);
		chk("reset time", t >= 10 && t <= 18, 1);
		repeat (30) @(posedge sys_clk);
		acc(0, WTC_STAT_ADDR, 8'h00);
		chk("status after wd reset", rd & 32'h19, stat_m());
		for (i = 0; i < 4; i++) begin
			p = 1 << (10 - 2 * i);
			acc(1, WTC_CTRL_ADDR, 8'h38 | 8'(i << 1));
			acc(1, WTC_CODE_ADDR, WTC_CODE_CLEAR);
			wait_for(p + 10);
			chk("interrupt action", {rst_req, nmi}, 2'b01);
			chk("detect time", t >= p * 3 / 4 - 4 && t <= p + 6, 1);
		end
		@(posedge sys_clk);
		wait_for(30);
		chk("repeat interrupt", t >= 12 && t <= 18, 1);
		acc(1, WTC_CTRL_ADDR, 8'h3f);
		acc(0, WTC_STAT_ADDR, 8'h00);
		chk("sticky select", rd & 32'h19, stat_m());
		// clear first so no overflow is already on its way when the hold starts
		acc(1, WTC_CODE_ADDR, WTC_CODE_CLEAR);
		mode.cpu_hold_mode <= 1'b1;
		@(posedge sys_clk);
		wait_for(100);
		chk("held", t, 100);
		mode.cpu_hold_mode <= 1'b0;
		wait_for(40);
		chk("resume", nmi, 1);
		acc(1, WTC_CODE_ADDR, WTC_CODE_DISABLE);
		acc(0, WTC_STAT_ADDR, 8'h00);
		chk("disable refused", rd & 32'h19, stat_m());
		acc(1, WTC_CODE_ADDR, WTC_CODE_CLEAR);
		acc(1, WTC_CTRL_ADDR, 8'h36);
		acc(1, WTC_CODE_ADDR, WTC_CODE_DISABLE);
		wait_for(100);
		chk("disabled quiet", t, 100);
		for (i = 0; i < 6; i++) begin
			c = 8'($random(seed));
			if (c == WTC_CODE_CLEAR || c == WTC_CODE_DISABLE || c == WTC_CODE_TRAP)
				c = c ^ 8'h01;
			acc(1, WTC_CODE_ADDR, c);
		end
		byteenable <= 4'he;
		acc(1, WTC_CTRL_ADDR, 8'h0e);
		byteenable <= 4'hf;
		acc(0, WTC_STAT_ADDR, 8'h00);
		chk("disabled status", rd, stat_m());
		acc(1, WTC_CODE_ADDR, WTC_CODE_TRAP);
		chk("trap commit", trap, m_trap);
		acc(1, WTC_CTRL_ADDR, 8'h0e);
		mode.low_speed_run_mode <= 1'b1;
		wait_for(100);
		chk("slow mode idle", t, 100);
		mode.low_speed_run_mode <= 1'b0;
		mode.divider_source_select <= 1'b1;
		wait_for(50);
		chk("slow source idle", t, 50);
		for (i = 0; i < 60 && nmi !== 1'b1; i++) begin
			mode.low_freq_tick <= 1'($random(seed));
			@(posedge sys_clk);
		end
		chk("slow overflow", nmi, 1);
		end_of_test();
	end
endmodule : testbench
bind wtc_watchdog wtc_props wtc_props_i (.sys_clk(sys_clk), .nrst(nrst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.mode(mode), .watchdog_nmi_request(watchdog_nmi_request), .wd_reset_request(wd_reset_request),
	.trap_area_commit(trap_area_commit));
`default_nettype wire
